// [logic/bldc_consts.vh]
// Purpose: shared constants of the hall commutation controller
// Assumes: 125 MHz system clock
// Notes:   definitions only
`ifndef BLDC_CONSTS_VH
`define BLDC_CONSTS_VH

`define CLK_KHZ          125000
`define CLK_PERIOD_NS    8

// register byte offsets
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_SPEED        8'h08
`define OFS_INT_STATUS   8'h0C
`define OFS_INT_MASK     8'h10

// control register fields
`define CTRL_ACC_LSB     0
`define CTRL_DEC_LSB     8
`define CTRL_ILIM_LSB    16

// reset values
`define ACC_RESET        8'h80
`define DEC_RESET        8'h80
`define ILIM_DEFAULT     8'h25
`define INT_MASK_RESET   4'h0

// interrupt status bit positions
`define INT_FAULT        0
`define INT_LOCK         1
`define INT_REVERSED     2
`define INT_HALL_BAD     3

// timing
`define LOCK_TIME_MS     3000
`define STILL_TIME_MS    50
`define RAMP_MAX_MS      5000
`define RAMP_STEPS       255
`define PWM_PERIOD_NS    40000
`define LOCK_CYCLES      (`LOCK_TIME_MS * `CLK_KHZ)
`define STILL_CYCLES     (`STILL_TIME_MS * `CLK_KHZ)
`define RAMP_UNIT_CYCLES \
  ((`RAMP_MAX_MS * `CLK_KHZ) / (`RAMP_STEPS * `RAMP_STEPS))
`define PWM_CYCLES       (`PWM_PERIOD_NS / `CLK_PERIOD_NS)
`define DUTY_WIN_SHIFT   16

`endif

// [logic/pwm_duty_meter.v]
// Purpose: turns a speed reference pulse train into an 8-bit duty
// Assumes: input already synchronised to sys_clk
// Notes:   reference must be much faster than the measuring window
`timescale 1ns/100ps
`include "bldc_consts.vh"

module pwm_duty_meter #(
  parameter WIN_SHIFT = `DUTY_WIN_SHIFT
) (
  input  wire       sys_clk,
  input  wire       sys_rst,
  input  wire       ce,
  input  wire       pwm_level,
  output reg  [7:0] duty
);

  reg  [WIN_SHIFT-1:0] win_cnt;
  reg  [WIN_SHIFT:0]   high_cnt;
  wire                 win_end;

  assign win_end = &win_cnt;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      win_cnt  <= {WIN_SHIFT{1'b0}};
      high_cnt <= {(WIN_SHIFT+1){1'b0}};
      duty     <= 8'h00;
    end else if (ce) begin
      win_cnt <= win_cnt + 1'b1;
      if (win_end) begin
        // full-high window overflows 8 bits, so saturate
        if (high_cnt[WIN_SHIFT])
          duty <= 8'hFF;
        else
          duty <= high_cnt[WIN_SHIFT-1:WIN_SHIFT-8];
        high_cnt <= {{WIN_SHIFT{1'b0}}, pwm_level};
      end else if (pwm_level) begin
        high_cnt <= high_cnt + 1'b1;
      end
    end
  end

endmodule // pwm_duty_meter

// [logic/bldc_hall_commutation_control.v]
// Purpose: hall commutation, ramps, current chopping, fault supervision
// Assumes: APB slave, zero wait states; pins pass two flip-flops
// Notes:   lock latch is cleared only by sys_rst (power cycle)
`timescale 1ns/100ps
`include "bldc_consts.vh"

// Overview of operation
// - direction change brakes, then reverses and ramps
// - halls give rotor position and speed
// - tach toggles on every commutation step
// - fault output while any fault present
// - fault output high during reset
// - hall states mirrored on three outputs
// - thermal trip removes motor current
// - lock cuts current after lock time
// - lock holds stop until power reset
// - lock applies default limit unless lower
// - selectable acceleration ramp, five seconds max
// - selectable deceleration ramp, five seconds max
// - PWM current limit, continuous and peak scaled
// - enable input high freewheels, low drives
// - brake input shorts windings
module bldc_hall_commutation_control #(
  parameter LOCK_CYCLES  = `LOCK_CYCLES,
  parameter STILL_CYCLES = `STILL_CYCLES,
  parameter RAMP_UNIT    = `RAMP_UNIT_CYCLES,
  parameter PWM_CYCLES   = `PWM_CYCLES
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire [2:0]  hall_in,
  input  wire        reverse_rotation_input,
  input  wire        brake_input,
  input  wire        drive_enable_input,
  input  wire        speed_ref_pwm,
  input  wire        undervoltage_in,
  input  wire        overvoltage_in,
  input  wire        overcurrent_in,
  input  wire        thermal_trip_in,
  input  wire [7:0]  current_sample,
  output reg  [5:0]  bridge_gate,
  output reg         rotation_pulse_out,
  output reg         fault_out,
  output reg  [2:0]  hall_out,
  output wire        irq
);

  localparam [1:0] ST_RUN    = 2'b00;
  localparam [1:0] ST_REVERT = 2'b01;
  localparam [1:0] ST_LOCKED = 2'b10;

  // pin synchronisers: stage one is read only by stage two
  reg  [8:0]  pin_meta;
  reg  [8:0]  pin_sync;
  wire [2:0]  hall;
  wire        rev_pin;
  wire        brake_pin;
  wire        disable_pin;
  wire        ref_pin;
  wire        uv;
  wire        ov;
  wire        oc_pin;
  wire        thermal;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_meta <= 9'h000;
      pin_sync <= 9'h000;
    end else if (ce) begin
      pin_meta <= {hall_in, reverse_rotation_input, brake_input,
                   drive_enable_input, speed_ref_pwm, undervoltage_in,
                   overvoltage_in};
      pin_sync <= pin_meta;
    end
  end

  reg  [1:0]  flt_meta;
  reg  [1:0]  flt_sync;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      flt_meta <= 2'b00;
      flt_sync <= 2'b00;
    end else if (ce) begin
      flt_meta <= {overcurrent_in, thermal_trip_in};
      flt_sync <= flt_meta;
    end
  end

  assign hall        = pin_sync[8:6];
  assign rev_pin     = pin_sync[5];
  assign brake_pin   = pin_sync[4];
  assign disable_pin = pin_sync[3];
  assign ref_pin     = pin_sync[2];
  assign uv          = pin_sync[1];
  assign ov          = pin_sync[0];
  assign oc_pin      = flt_sync[1];
  assign thermal     = flt_sync[0];

  // hall code to step 0..5, 7 when invalid
  function [2:0] hall_step;
    input [2:0] code;
    begin
      case (code)
        3'h1:    hall_step = 3'd0;
        3'h3:    hall_step = 3'd1;
        3'h2:    hall_step = 3'd2;
        3'h6:    hall_step = 3'd3;
        3'h4:    hall_step = 3'd4;
        3'h5:    hall_step = 3'd5;
        default: hall_step = 3'd7;
      endcase
    end
  endfunction

  // gates {uh,vh,wh,ul,vl,wl}; reverse swaps high and low sides
  function [5:0] comm;
    input [2:0] step;
    input       rev;
    reg   [5:0] fwd;
    begin
      case (step)
        3'd0:    fwd = 6'b100_010;
        3'd1:    fwd = 6'b100_001;
        3'd2:    fwd = 6'b010_001;
        3'd3:    fwd = 6'b010_100;
        3'd4:    fwd = 6'b001_100;
        3'd5:    fwd = 6'b001_010;
        default: fwd = 6'b000_000;
      endcase
      comm = rev ? {fwd[2:0], fwd[5:3]} : fwd;
    end
  endfunction

  // registers
  reg  [7:0]  acc_time;
  reg  [7:0]  dec_time;
  reg  [7:0]  ilim_set;
  reg  [3:0]  int_status;
  reg  [3:0]  int_mask;
  reg  [1:0]  state;
  reg         dir;
  reg         lock_latched;
  reg  [2:0]  hall_prev;
  reg  [23:0] quiet_cnt;
  reg  [23:0] hall_period;
  reg  [31:0] lock_cnt;
  reg  [7:0]  speed_cmd;
  reg  [21:0] ramp_cnt;
  reg  [12:0] carrier;
  reg         chop;
  reg         fault_prev;
  wire [7:0]  setpoint;

  pwm_duty_meter u_duty (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .pwm_level (ref_pin),
    .duty      (setpoint)
  );

  wire [7:0]  ilim_eff;
  wire        hall_edge = (hall != hall_prev);
  wire        hall_ok   = (hall_step(hall) != 3'd7);
  // reset leaves an invalid code behind, so no false tach step
  wire        step_edge = hall_edge && hall_ok &&
                          (hall_step(hall_prev) != 3'd7);
  wire        oc_peak   = ({1'b0, current_sample} > {ilim_eff, 1'b0});
  wire        any_fault = uv | ov | oc_pin | oc_peak | thermal |
                          lock_latched;
  wire        drive_on  = (state == ST_RUN) && !disable_pin && !brake_pin
                          && !any_fault;
  wire        rev_req   = (rev_pin != dir);
  wire        still     = (quiet_cnt >= STILL_CYCLES);
  wire [7:0]  target    = drive_on ? setpoint : 8'h00;
  wire        ramp_up   = (target > speed_cmd);
  wire [21:0] ramp_len;
  wire [20:0] duty_thr;

  // lock tightens the limit to the default unless set lower
  assign ilim_eff = (lock_latched && ilim_set > `ILIM_DEFAULT) ?
                    `ILIM_DEFAULT : ilim_set;
  assign ramp_len = (ramp_up ? acc_time : dec_time) *
                    RAMP_UNIT[13:0];
  assign duty_thr = speed_cmd * PWM_CYCLES[12:0];

  // mode, direction and lock supervision
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      state        <= ST_RUN;
      dir          <= 1'b0;
      lock_latched <= 1'b0;
      lock_cnt     <= 32'h0000_0000;
    end else if (ce) begin
      if (hall_edge || !drive_on || speed_cmd == 8'h00)
        lock_cnt <= 32'h0000_0000;
      else if (lock_cnt < LOCK_CYCLES)
        lock_cnt <= lock_cnt + 1'b1;
      case (state)
        ST_RUN: begin
          if (lock_cnt >= LOCK_CYCLES) begin
            state        <= ST_LOCKED;
            lock_latched <= 1'b1;
          end else if (rev_req) begin
            state <= ST_REVERT;
          end
        end
        ST_REVERT: begin
          // wait for standstill, then spin the other way
          if (still) begin
            dir   <= rev_pin;
            state <= ST_RUN;
          end
        end
        ST_LOCKED: state <= ST_LOCKED;
        default:   state <= ST_RUN;
      endcase
    end
  end

  // hall tracking and speed measurement
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      hall_prev          <= 3'h0;
      quiet_cnt          <= 24'h000000;
      hall_period        <= 24'hFFFFFF;
      rotation_pulse_out <= 1'b0;
      hall_out           <= 3'h0;
    end else if (ce) begin
      hall_prev <= hall;
      hall_out  <= hall;
      if (step_edge)
        rotation_pulse_out <= ~rotation_pulse_out;
      if (hall_edge) begin
        hall_period <= quiet_cnt;
        quiet_cnt   <= 24'h000000;
      end else if (quiet_cnt != 24'hFFFFFF) begin
        quiet_cnt <= quiet_cnt + 1'b1;
      end
      if (quiet_cnt == 24'hFFFFFF)
        hall_period <= 24'hFFFFFF;
    end
  end

  // speed ramp, one step of the command per ramp_len + 1 cycles
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      speed_cmd <= 8'h00;
      ramp_cnt  <= 22'h000000;
    end else if (ce) begin
      if (!drive_on) begin
        // freewheel and braking drop the command at once
        speed_cmd <= 8'h00;
        ramp_cnt  <= 22'h000000;
      end else if (target == speed_cmd) begin
        ramp_cnt <= 22'h000000;
      end else if (ramp_cnt >= ramp_len) begin
        ramp_cnt <= 22'h000000;
        if (ramp_up)
          speed_cmd <= speed_cmd + 1'b1;
        else
          speed_cmd <= speed_cmd - 1'b1;
      end else begin
        ramp_cnt <= ramp_cnt + 1'b1;
      end
    end
  end

  // carrier and cycle-by-cycle current chopping
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      carrier <= 13'h0000;
      chop    <= 1'b0;
    end else if (ce) begin
      if (carrier == PWM_CYCLES[12:0] - 13'h0001) begin
        carrier <= 13'h0000;
        chop    <= 1'b0;
      end else begin
        carrier <= carrier + 1'b1;
        if (current_sample > ilim_eff)
          chop <= 1'b1;
      end
    end
  end

  // bridge gates; no dead time here, the gate driver must add it
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      bridge_gate <= 6'b000_000;
    end else if (ce) begin
      if (any_fault || state == ST_LOCKED)
        bridge_gate <= 6'b000_000;
      else if (disable_pin)
        bridge_gate <= 6'b000_000;
      else if (brake_pin || state == ST_REVERT)
        bridge_gate <= 6'b000_111;
      else if ({8'h00, carrier} < duty_thr && !chop)
        bridge_gate <= comm(hall_step(hall), dir);
      else
        bridge_gate <= comm(hall_step(hall), dir) & 6'b000_111;
    end
  end

  // fault output
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_out  <= 1'b1;
      fault_prev <= 1'b0;
    end else if (ce) begin
      fault_out  <= any_fault;
      fault_prev <= any_fault;
    end
  end

  // apb slave, no wait states
  wire        wr_en = psel && penable && pwrite;
  wire        rd_en = psel && penable && !pwrite;
  wire [3:0]  int_set;
  wire        rd_int = rd_en && (paddr == `OFS_INT_STATUS);

  assign pready  = 1'b1;
  assign int_set = {step_edge ? 1'b0 : (hall_edge && !hall_ok),
                    (state == ST_REVERT) && still,
                    (state == ST_RUN) && (lock_cnt >= LOCK_CYCLES),
                    any_fault && !fault_prev};
  assign irq     = |(int_status & int_mask);

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      acc_time   <= `ACC_RESET;
      dec_time   <= `DEC_RESET;
      ilim_set   <= `ILIM_DEFAULT;
      int_mask   <= `INT_MASK_RESET;
      int_status <= 4'h0;
      prdata     <= 32'h0000_0000;
      pslverr    <= 1'b0;
    end else if (ce) begin
      // a read clears, but a same-cycle event still lands
      int_status <= (rd_int ? 4'h0 : int_status) | int_set;
      pslverr    <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h0000_0000;
        if (paddr == `OFS_CTRL)
          prdata <= {8'h00, ilim_set, dec_time, acc_time};
        else if (paddr == `OFS_STATUS)
          prdata <= {8'h00, speed_cmd, setpoint, lock_latched,
                     fault_out, dir, state, hall};
        else if (paddr == `OFS_SPEED)
          prdata <= {8'h00, hall_period};
        else if (paddr == `OFS_INT_STATUS)
          prdata <= {28'h0000000, int_status | int_set};
        else if (paddr == `OFS_INT_MASK)
          prdata <= {28'h0000000, int_mask};
        else
          pslverr <= 1'b1;
      end
      if (wr_en) begin
        if (paddr == `OFS_CTRL) begin
          acc_time <= pwdata[`CTRL_ACC_LSB +: 8];
          dec_time <= pwdata[`CTRL_DEC_LSB +: 8];
          ilim_set <= pwdata[`CTRL_ILIM_LSB +: 8];
        end else if (paddr == `OFS_INT_MASK) begin
          int_mask <= pwdata[3:0];
        end
      end
    end
  end

endmodule // bldc_hall_commutation_control

// [dv/hall_motor_model.sv]
// Purpose: hall sensor model of a spinning rotor
// Assumes: one hall step every STEP_CYC clocks while run is high
// Notes:   stops dead when run is low, halls then hold still
`timescale 1ns/100ps
module hall_motor_model #(
  parameter STEP_CYC = 40
) (
  input  wire        sys_clk,
  input  wire        run,
  input  wire        fwd,
  output logic [2:0] hall
);
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int         pos = 0;
  int         cnt = 0;
  always @(posedge sys_clk) begin
    cnt <= (run && cnt < STEP_CYC - 1) ? cnt + 1 : 0;
    if (run && cnt == STEP_CYC - 1)
      pos <= fwd ? (pos + 1) % 6 : (pos + 5) % 6;
  end
  assign hall = seq[pos];
endmodule // hall_motor_model

// [dv/bldc_hall_commutation_control_properties.sv]
// Purpose: port checker of the hall commutation controller
// Assumes: ce low only while pins stand still; pins pass two flip-flops
// Notes:   margins of a few cycles cover the pin synchronisers
`timescale 1ns/100ps
module bldc_hall_commutation_control_properties (
  input wire       sys_clk,
  input wire       sys_rst,
  input wire       psel,
  input wire       penable,
  input wire [7:0] paddr,
  input wire       pslverr,
  input wire [2:0] hall_in,
  input wire       reverse_rotation_input,
  input wire       brake_input,
  input wire       drive_enable_input,
  input wire       thermal_trip_in,
  input wire [5:0] bridge_gate,
  input wire       rotation_pulse_out,
  input wire       fault_out,
  input wire [2:0] hall_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] hall_prev;
  logic [3:0] hall_age;
  always @(posedge sys_clk) begin
    hall_prev <= hall_in;
    if (sys_rst)
      hall_age <= 4'hF;
    else if (hall_in != hall_prev)
      hall_age <= 4'h0;
    else if (hall_age != 4'hF)
      hall_age <= hall_age + 4'h1;
  end
  a_fault_in_reset: assert property (disable iff (1'b0)
    sys_rst |=> fault_out) else $error("fault low in reset");
  a_thermal_fault: assert property (thermal_trip_in[*3] |=> fault_out)
    else $error("thermal trip without fault");
  a_thermal_cut: assert property (thermal_trip_in[*6]
    |-> bridge_gate[5:3] == 3'b000) else $error("current not removed");
  a_enable_off: assert property (drive_enable_input[*6]
    |-> bridge_gate == 6'h00) else $error("gates on while disabled");
  a_invalid_hall: assert property ((hall_in == 3'h0)[*6]
    |-> bridge_gate == 6'h00) else $error("gates on with bad code");
  a_brake_short: assert property ((brake_input && !drive_enable_input
    && !fault_out)[*6] |-> bridge_gate == 6'h07)
    else $error("brake not shorting");
  a_tach_cause: assert property ($changed(rotation_pulse_out)
    |-> hall_age < 4'h5) else $error("tach toggled without hall edge");
  a_reverse_brake: assert property ($changed(reverse_rotation_input)
    && !drive_enable_input && !fault_out && !brake_input
    |-> ##6 bridge_gate == 6'h07) else $error("reversal without braking");
  a_hall_mirror: assert property ((!sys_rst)[*4]
    |-> hall_out == $past(hall_in, 3)) else $error("hall copy wrong");
  a_unmapped_err: assert property (psel && !penable
    |=> pslverr == ($past(paddr) > 8'h10)) else $error("slave error wrong");
  c_brake: cover property (brake_input[*6]);
  c_reverse: cover property ($changed(reverse_rotation_input));
  c_tach: cover property ($changed(rotation_pulse_out));
endmodule // bldc_hall_commutation_control_properties

bind bldc_hall_commutation_control bldc_hall_commutation_control_properties
  u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr), .hall_in(hall_in),
  .reverse_rotation_input(reverse_rotation_input),
  .brake_input(brake_input), .drive_enable_input(drive_enable_input),
  .thermal_trip_in(thermal_trip_in), .bridge_gate(bridge_gate),
  .rotation_pulse_out(rotation_pulse_out), .fault_out(fault_out),
  .hall_out(hall_out));

// [dv/bldc_hall_commutation_control_tb.sv]
// Purpose: self-checking bench of the hall commutation controller
// Assumes: shortened lock, standstill and pwm counts
// Notes:   the setpoint window is long and dominates the run time
`timescale 1ns/100ps
module bldc_hall_commutation_control_tb;
  logic        sys_clk;
  logic        sys_rst;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr, cur;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, irq, tach, fault_out;
  logic [2:0]  hall, hall_out;
  logic        rev, brake, en, spd, run, fwd, bad, ce, err;
  logic [3:0]  flt;
  logic [5:0]  gate;
  logic [15:0] spd_cnt;
  int          mismatches, comparisons;

  hall_motor_model u_motor (.sys_clk(sys_clk), .run(run), .fwd(fwd),
    .hall(hall));
  bldc_hall_commutation_control #(.LOCK_CYCLES(200), .STILL_CYCLES(50),
    .RAMP_UNIT(1), .PWM_CYCLES(32)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .hall_in(bad ? 3'h0 : hall), .reverse_rotation_input(rev),
    .brake_input(brake), .drive_enable_input(en), .speed_ref_pwm(spd),
    .undervoltage_in(flt[0]), .overvoltage_in(flt[1]),
    .overcurrent_in(flt[2]), .thermal_trip_in(flt[3]),
    .current_sample(cur), .bridge_gate(gate), .rotation_pulse_out(tach),
    .fault_out(fault_out), .hall_out(hall_out), .irq(irq));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // three quarter duty setpoint
  always @(posedge sys_clk) begin
    spd_cnt <= spd_cnt + 16'h1;
    spd <= spd_cnt[1:0] != 2'h0;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h00258080);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h00, 32'h00250000);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h00250000);
    ce <= 1'b0;
    apb(1'b1, 8'h00, 32'h00123456);
    ce <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h00250000);
  endtask

  task automatic t_faults;
    apb(1'b0, 8'h0C, 32'h0);
    apb(1'b1, 8'h10, 32'h1);
    for (int i = 0; i < 5; i++) begin
      if (i == 4)
        apb(1'b1, 8'h10, 32'h0);
      flt <= 4'h1 << (i % 4);
      repeat (8) @(posedge sys_clk);
      chk(fault_out, 1'b1);
      chk(irq, i < 4);
      flt <= 4'h0;
      repeat (8) @(posedge sys_clk);
      chk(fault_out, 1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(q[0], 1'b1);
      chk(irq, 1'b0);
    end
    cur <= 8'h4B;
    repeat (4) @(posedge sys_clk);
    chk(fault_out, 1'b1);
    cur <= 8'h4A;
    repeat (4) @(posedge sys_clk);
    chk(fault_out, 1'b0);
    cur <= 8'h00;
  endtask

  task automatic step_chk(input logic [23:0] tbl);
    logic [2:0] h0;
    logic       t0;
    h0 = hall;
    t0 = tach;
    for (int i = 0; i < 80 && hall === h0; i++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    chk(gate[2:0], tbl[hall*3 +: 3]);
    chk(hall_out, hall);
    chk(tach, !t0);
  endtask

  task automatic t_spin;
    for (int i = 0; i < 90 && q[15:8] === 8'h00; i++) begin
      repeat (1000) @(posedge sys_clk);
      apb(1'b0, 8'h04, 32'h0);
    end
    en <= 1'b0;
    run <= 1'b1;
    repeat (6) step_chk(24'h114250);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h00000027);
    en <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(gate, 6'h00);
    en <= 1'b0;
    brake <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(gate, 6'h07);
    brake <= 1'b0;
    run <= 1'b0;
    bad <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(gate, 6'h00);
    bad <= 1'b0;
  endtask

  task automatic t_reverse;
    rev <= 1'b1;
    repeat (9) @(posedge sys_clk);
    chk(gate, 6'h07);
    repeat (70) @(posedge sys_clk);
    apb(1'b0, 8'h04, 32'h0);
    chk(q[5:3], 3'h4);
    fwd <= 1'b0;
    run <= 1'b1;
    step_chk(24'h0898A0);
  endtask

  task automatic t_lock;
    run <= 1'b0;
    repeat (230) @(posedge sys_clk);
    chk(gate, 6'h00);
    chk(fault_out, 1'b1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q[7], 1'b1);
    run <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk(gate, 6'h00);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk(fault_out, 1'b0);
  endtask

  task automatic complete_run;
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    repeat (98000) @(posedge sys_clk);
    mismatches++;
    complete_run;
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, q} = '0;
    {rev, brake, spd, run, bad, flt, spd_cnt, cur, err} = '0;
    ce = 1'b1;
    en = 1'b1;
    fwd = 1'b1;
    repeat (12) @(posedge sys_clk);
    chk(fault_out, 1'b1);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_faults;
    t_spin;
    t_reverse;
    t_lock;
    complete_run;
  end
endmodule // bldc_hall_commutation_control_tb
